// >>> src/pcic_regs.svh
// Buffer memory offsets, codes and timing counts for the controller info clear block.
`ifndef PCIC_REGS_SVH
`define PCIC_REGS_SVH
`define PCIC_ADDR_W 12
`define PCIC_OFS_CLEAR_REQ 12'h080
`define PCIC_OFS_CH1_SEQ 12'h255
`define PCIC_OFS_CH1_ERR 12'h25a
`define PCIC_OFS_CH2_SEQ 12'h265
`define PCIC_OFS_CH2_ERR 12'h26a
`define PCIC_SYS_LO 12'h100
`define PCIC_SYS_HI 12'h1ff
`define PCIC_CLEAR_CODE 16'h4c43
`define PCIC_DONE_CODE 16'h0000
`define PCIC_SEQ_INIT 16'h0000
`define PCIC_ERR_RANGE 16'h7140
`define PCIC_ERR_CMD 16'h7142
`define PCIC_ERR_DEV 16'h714d
`define PCIC_CLEAR_NS 100
`define PCIC_CLOCK_NS 5
`define PCIC_CLEAR_CYC ((`PCIC_CLEAR_NS + `PCIC_CLOCK_NS - 1) / `PCIC_CLOCK_NS)
`endif

// >>> src/pcic_pkg.sv
// Types shared by the controller info clear block.
package pcic_pkg;
	typedef enum logic [2:0] {PCIC_IDLE, PCIC_WAIT_REINIT, PCIC_CLEAR, PCIC_DONE} pcic_state_e;
	typedef logic [15:0] pcic_word_t;
	typedef enum logic [1:0] {PCIC_INFO_NONE, PCIC_INFO_FETCH, PCIC_INFO_VALID} pcic_info_e;
endpackage : pcic_pkg

// >>> src/pcic_sync.sv
// Two flip-flop synchroniser for a level from outside the clock domain.
module pcic_sync
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Level in and out.
	input wire logic din,
	output logic dout
);
	logic s1_ff;
	logic s2_ff;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
		end
		else
		begin
			s1_ff <= din;
			s2_ff <= s1_ff;
		end
	end
	assign dout = s2_ff;
endmodule : pcic_sync

// >>> src/pcic_info_cache.sv
// Cached target controller type information with fetch-on-first-access.
`include "pcic_regs.svh"
module pcic_info_cache
	import pcic_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Control.
	input wire logic clear,
	input wire logic access,
	input wire logic fetch_done,
	input wire pcic_word_t fetch_type,
	// State.
	output logic fetch_req,
	output logic info_valid,
	output pcic_word_t info_type
);
	pcic_info_e st_ff;
	pcic_info_e nxt_st;
	pcic_word_t type_ff;
	pcic_word_t nxt_type;
	always_comb
	begin
		nxt_st = st_ff;
		nxt_type = type_ff;
		if (clear)
		begin
			nxt_st = PCIC_INFO_NONE;
			nxt_type = 16'h0000;
		end
		else
		begin
			unique case (st_ff)
				PCIC_INFO_NONE:
					if (access)
						nxt_st = PCIC_INFO_FETCH;
				PCIC_INFO_FETCH:
					if (fetch_done)
					begin
						nxt_st = PCIC_INFO_VALID;
						nxt_type = fetch_type;
					end
				PCIC_INFO_VALID:
					nxt_st = PCIC_INFO_VALID;
			endcase
		end
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			st_ff <= PCIC_INFO_NONE;
			type_ff <= 16'h0000;
		end
		else
		begin
			st_ff <= nxt_st;
			type_ff <= nxt_type;
		end
	end
	assign fetch_req = (st_ff == PCIC_INFO_FETCH);
	assign info_valid = (st_ff == PCIC_INFO_VALID);
	assign info_type = type_ff;
endmodule : pcic_info_cache

// >>> src/pcic_clear_handler.sv
// Controller info clear handshake, sequence status and transmit error code words.
// Notes on behaviour
// - Run clear, then write zero back.
// - Clear reinitializes both sequence status words.
// - Serial receive data discarded while clearing.
// - Modem line dropped when clearing starts.
// - Clear waits for running reinitialize.
// - Cache cleared at reset and controller reset.
// - First access fetches and caches controller type.
// - Narrowed range reports error 7140h.
// - Unusable commands report 7142h or 714dh.
// - Negative acknowledge stores code; zero write clears.
// - Error lamp may stay off on NAK.
// - Each buffer address holds one 16-bit word.
// - System area refuses outside writes.
// - Read-only words ignore writes.
`include "pcic_regs.svh"
module pcic_clear_handler
	import pcic_pkg::*;
#(
	parameter int CLEAR_CYCLES = `PCIC_CLEAR_CYC
)
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Buffer memory port from the controller.
	input wire logic bm_wr,
	input wire logic bm_rd,
	input wire logic [`PCIC_ADDR_W-1:0] bm_addr,
	input wire pcic_pkg::pcic_word_t bm_wdata,
	output pcic_pkg::pcic_word_t bm_rdata,
	output logic bm_rvalid,
	// Controller status.
	input wire logic cpu_reset,
	input wire logic reinit_busy,
	// Serial receive side.
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_out_valid,
	output logic [7:0] rx_out_data,
	// Modem line from the pin.
	input wire logic modem_present,
	output logic modem_line_on,
	// Host protocol engine.
	input wire logic hp_access,
	input wire logic hp_fetch_done,
	input wire pcic_pkg::pcic_word_t hp_fetch_type,
	input wire logic hp_fetch_bad_range,
	input wire logic hp_fetch_bad_cmd,
	input wire logic hp_fetch_bad_dev,
	input wire logic nak_ch1,
	input wire logic nak_ch2,
	input wire pcic_pkg::pcic_word_t nak_code,
	input wire pcic_pkg::pcic_word_t seq_ch1_in,
	input wire pcic_pkg::pcic_word_t seq_ch2_in,
	input wire logic seq_ch1_upd,
	input wire logic seq_ch2_upd,
	output logic hp_fetch_req,
	output logic hp_info_valid,
	output logic err_lamp,
	output logic clear_busy
);
	import pcic_pkg::*;

	function automatic logic is_sys(input logic [`PCIC_ADDR_W-1:0] a);
		is_sys = (a >= `PCIC_SYS_LO) && (a <= `PCIC_SYS_HI);
	endfunction : is_sys

	pcic_state_e st_ff;
	pcic_state_e nxt_st;
	pcic_word_t req_ff;
	pcic_word_t nxt_req;
	pcic_word_t seq1_ff;
	pcic_word_t nxt_seq1;
	pcic_word_t seq2_ff;
	pcic_word_t nxt_seq2;
	pcic_word_t err1_ff;
	pcic_word_t nxt_err1;
	pcic_word_t err2_ff;
	pcic_word_t nxt_err2;
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	pcic_word_t rdata_ff;
	pcic_word_t nxt_rdata;
	logic rvalid_ff;
	logic rxv_ff;
	logic nxt_rxv;
	logic [7:0] rxd_ff;
	logic modem_ff;
	logic nxt_modem;
	logic cpu_reset_s;
	logic modem_s;
	logic fetch_req_w;
	logic info_valid_w;
	logic fetch_req_ff;
	logic info_valid_ff;
	logic busy_ff;
	logic nxt_busy;
	logic cache_clear;
	pcic_word_t fetch_err;

	pcic_sync u_sync_cpu_reset
	(
		.clock(clock),
		.rst(rst),
		.din(cpu_reset),
		.dout(cpu_reset_s)
	);

	pcic_sync u_sync_modem
	(
		.clock(clock),
		.rst(rst),
		.din(modem_present),
		.dout(modem_s)
	);

	// The cache drops on a finished clear; controller reset clears it too.
	assign cache_clear = cpu_reset_s || (st_ff == PCIC_CLEAR && cnt_ff == 16'h0000);

	pcic_info_cache u_cache
	(
		.clock(clock),
		.rst(rst),
		.clear(cache_clear),
		.access(hp_access),
		.fetch_done(hp_fetch_done),
		.fetch_type(hp_fetch_type),
		.fetch_req(fetch_req_w),
		.info_valid(info_valid_w),
		.info_type()
	);

	// A bad fetch leaves a usable but limited cache, so the code comes from the cause.
	always_comb
	begin
		fetch_err = `PCIC_DONE_CODE;
		if (hp_fetch_bad_range)
			fetch_err = `PCIC_ERR_RANGE;
		else if (hp_fetch_bad_cmd)
			fetch_err = `PCIC_ERR_CMD;
		else if (hp_fetch_bad_dev)
			fetch_err = `PCIC_ERR_DEV;
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_req = req_ff;
		nxt_cnt = cnt_ff;
		nxt_seq1 = seq1_ff;
		nxt_seq2 = seq2_ff;
		nxt_err1 = err1_ff;
		nxt_err2 = err2_ff;
		nxt_modem = modem_ff;
		nxt_rdata = rdata_ff;
		nxt_rxv = 1'b0;
		if (seq_ch1_upd)
			nxt_seq1 = seq_ch1_in;
		if (seq_ch2_upd)
			nxt_seq2 = seq_ch2_in;
		// Writes land first so that a hardware store in the same cycle wins.
		if (bm_wr && !is_sys(bm_addr))
		begin
			unique case (bm_addr)
				`PCIC_OFS_CLEAR_REQ:
					if (st_ff == PCIC_IDLE)
						nxt_req = bm_wdata;
				`PCIC_OFS_CH1_ERR:
					nxt_err1 = bm_wdata;
				`PCIC_OFS_CH2_ERR:
					nxt_err2 = bm_wdata;
				default:
					nxt_req = nxt_req;
			endcase
		end
		if (nak_ch1)
			nxt_err1 = nak_code;
		else if (hp_fetch_done && fetch_err != `PCIC_DONE_CODE)
			nxt_err1 = fetch_err;
		if (nak_ch2)
			nxt_err2 = nak_code;
		// The line follows the pin while idle and in the done step, and is taken before the state step so that a start can drop it.
		if (st_ff == PCIC_IDLE)
			nxt_modem = modem_s;
		unique case (st_ff)
			PCIC_IDLE:
				if (req_ff == `PCIC_CLEAR_CODE)
				begin
					if (reinit_busy)
						nxt_st = PCIC_WAIT_REINIT;
					else
					begin
						nxt_st = PCIC_CLEAR;
						nxt_cnt = 16'(CLEAR_CYCLES - 1);
						nxt_modem = 1'b0;
					end
				end
			PCIC_WAIT_REINIT:
				if (!reinit_busy)
				begin
					nxt_st = PCIC_CLEAR;
					nxt_cnt = 16'(CLEAR_CYCLES - 1);
					nxt_modem = 1'b0;
				end
			PCIC_CLEAR:
				if (cnt_ff == 16'h0000)
				begin
					nxt_st = PCIC_DONE;
					nxt_seq1 = `PCIC_SEQ_INIT;
					nxt_seq2 = `PCIC_SEQ_INIT;
				end
				else
					nxt_cnt = cnt_ff - 16'h0001;
			PCIC_DONE:
			begin
				nxt_st = PCIC_IDLE;
				nxt_req = `PCIC_DONE_CODE;
				nxt_modem = modem_s;
			end
		endcase
		nxt_busy = (nxt_st != PCIC_IDLE);
		if (rx_valid && st_ff == PCIC_IDLE)
			nxt_rxv = 1'b1;
		if (bm_rd)
		begin
			unique case (bm_addr)
				`PCIC_OFS_CLEAR_REQ:
					nxt_rdata = req_ff;
				`PCIC_OFS_CH1_SEQ:
					nxt_rdata = seq1_ff;
				`PCIC_OFS_CH1_ERR:
					nxt_rdata = err1_ff;
				`PCIC_OFS_CH2_SEQ:
					nxt_rdata = seq2_ff;
				`PCIC_OFS_CH2_ERR:
					nxt_rdata = err2_ff;
				default:
					nxt_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			st_ff <= PCIC_IDLE;
			req_ff <= 16'h0000;
			cnt_ff <= 16'h0000;
			seq1_ff <= 16'h0000;
			seq2_ff <= 16'h0000;
			err1_ff <= 16'h0000;
			err2_ff <= 16'h0000;
			modem_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			rvalid_ff <= 1'b0;
			rxv_ff <= 1'b0;
			rxd_ff <= 8'h00;
			fetch_req_ff <= 1'b0;
			info_valid_ff <= 1'b0;
			busy_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			req_ff <= nxt_req;
			cnt_ff <= nxt_cnt;
			seq1_ff <= nxt_seq1;
			seq2_ff <= nxt_seq2;
			err1_ff <= nxt_err1;
			err2_ff <= nxt_err2;
			modem_ff <= nxt_modem;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= bm_rd;
			rxv_ff <= nxt_rxv;
			rxd_ff <= rx_data;
			fetch_req_ff <= fetch_req_w;
			info_valid_ff <= info_valid_w;
			busy_ff <= nxt_busy;
		end
	end

	assign bm_rdata = rdata_ff;
	assign bm_rvalid = rvalid_ff;
	assign rx_out_valid = rxv_ff;
	assign rx_out_data = rxd_ff;
	assign modem_line_on = modem_ff;
	assign hp_fetch_req = fetch_req_ff;
	assign hp_info_valid = info_valid_ff;
	// The lamp is left dark on a negative acknowledge.
	assign err_lamp = 1'b0;
	assign clear_busy = busy_ff;

	AST_DONE_WRITE: assert property (@(posedge clock) disable iff (rst) (st_ff == PCIC_DONE) |=> (req_ff == 16'h0000)) else $error("done not written");
	AST_SEQ_INIT: assert property (@(posedge clock) disable iff (rst) (st_ff == PCIC_CLEAR && cnt_ff == 16'h0000 && !seq_ch1_upd) |=> (seq1_ff == 16'h0000)) else $error("seq not reset");
	AST_RX_DROP: assert property (@(posedge clock) disable iff (rst) (st_ff != PCIC_IDLE) |=> !rx_out_valid) else $error("rx passed during clear");
	AST_MODEM_DROP: assert property (@(posedge clock) disable iff (rst) (st_ff == PCIC_IDLE && req_ff == 16'h4c43 && !reinit_busy) |=> (!modem_line_on && st_ff == PCIC_CLEAR)) else $error("modem not dropped");
	AST_DEFER: assert property (@(posedge clock) disable iff (rst) (st_ff == PCIC_WAIT_REINIT && reinit_busy) |=> (st_ff == PCIC_WAIT_REINIT)) else $error("clear ran during reinit");
	AST_NAK_STORE: assert property (@(posedge clock) disable iff (rst) nak_ch1 |=> (err1_ff == $past(nak_code))) else $error("nak code lost");
	AST_SYS_WRITE: assert property (@(posedge clock) disable iff (rst) (bm_wr && is_sys(bm_addr) && !nak_ch1 && !hp_fetch_done) |=> $stable(err1_ff)) else $error("system write took effect");
	AST_BAD_REQ: assert property (@(posedge clock) disable iff (rst) (st_ff == PCIC_IDLE && req_ff != 16'h4c43) |=> (st_ff == PCIC_IDLE)) else $error("bad code started clear");
	AST_CLEAR_LEN: assert property (@(posedge clock) disable iff (rst) $rose(st_ff == PCIC_CLEAR) |-> ##[1:1000] (st_ff == PCIC_DONE)) else $error("clear did not finish");
endmodule : pcic_clear_handler

// >>> sim/pcic_partner.sv
// Host protocol engine model that answers controller type fetches.
module pcic_partner
	import pcic_pkg::*;
#(
	parameter int DELAY = 3
)
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Fetch handshake.
	input wire logic hp_fetch_req,
	input wire logic [2:0] bad_mode,
	output logic hp_fetch_done,
	output pcic_pkg::pcic_word_t hp_fetch_type,
	output logic hp_fetch_bad_range,
	output logic hp_fetch_bad_cmd,
	output logic hp_fetch_bad_dev
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam pcic_word_t TYPE = 16'h5a3c;
	assign hp_fetch_bad_range = bad_mode[0];
	assign hp_fetch_bad_cmd = bad_mode[1];
	assign hp_fetch_bad_dev = bad_mode[2];
	// Type shows its inverse outside the answer so a stale sample is caught.
	initial
	begin
		hp_fetch_done = 1'b0;
		hp_fetch_type = ~TYPE;
		forever
		begin
			@(posedge clock);
			if (!rst && hp_fetch_req === 1'b1)
			begin
				repeat (DELAY) @(posedge clock);
				hp_fetch_done <= 1'b1;
				hp_fetch_type <= TYPE;
				@(posedge clock);
				hp_fetch_done <= 1'b0;
				hp_fetch_type <= ~TYPE;
				@(posedge clock);
			end
		end
	end
endmodule : pcic_partner

// >>> sim/cpu_info_clear_handler_test.sv
// Self-checking bench for the controller info clear block.
`include "pcic_regs.svh"
module cpu_info_clear_handler_test
	import pcic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CLR = 12;
	logic clock, rst, bm_wr, bm_rd, bm_rvalid, cpu_reset, reinit_busy, rx_valid, rx_out_valid;
	logic modem_present, modem_line_on, hp_access, hp_fetch_done, bad_r, bad_c, bad_d;
	logic nak_ch1, nak_ch2, seq_ch1_upd, seq_ch2_upd, hp_fetch_req, hp_info_valid, err_lamp, clear_busy;
	logic [11:0] bm_addr;
	logic [7:0] rx_data, rx_out_data;
	logic [2:0] bad_mode;
	pcic_word_t bm_wdata, bm_rdata, hp_fetch_type, nak_code, seq_ch1_in, seq_ch2_in, rv;
	int err_count, checks;
	pcic_clear_handler #(.CLEAR_CYCLES(CLR)) dut (.clock(clock), .rst(rst), .bm_wr(bm_wr), .bm_rd(bm_rd),
		.bm_addr(bm_addr), .bm_wdata(bm_wdata), .bm_rdata(bm_rdata), .bm_rvalid(bm_rvalid),
		.cpu_reset(cpu_reset), .reinit_busy(reinit_busy), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data), .modem_present(modem_present),
		.modem_line_on(modem_line_on), .hp_access(hp_access), .hp_fetch_done(hp_fetch_done),
		.hp_fetch_type(hp_fetch_type), .hp_fetch_bad_range(bad_r), .hp_fetch_bad_cmd(bad_c),
		.hp_fetch_bad_dev(bad_d), .nak_ch1(nak_ch1), .nak_ch2(nak_ch2), .nak_code(nak_code),
		.seq_ch1_in(seq_ch1_in), .seq_ch2_in(seq_ch2_in), .seq_ch1_upd(seq_ch1_upd),
		.seq_ch2_upd(seq_ch2_upd), .hp_fetch_req(hp_fetch_req), .hp_info_valid(hp_info_valid),
		.err_lamp(err_lamp), .clear_busy(clear_busy));
	pcic_partner u_partner (.clock(clock), .rst(rst), .hp_fetch_req(hp_fetch_req), .bad_mode(bad_mode),
		.hp_fetch_done(hp_fetch_done), .hp_fetch_type(hp_fetch_type), .hp_fetch_bad_range(bad_r),
		.hp_fetch_bad_cmd(bad_c), .hp_fetch_bad_dev(bad_d));
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task tally_and_finish;
		$display("errors=%0d checks=%0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	task chk(input pcic_word_t got, input pcic_word_t exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [11:0] a, input pcic_word_t d);
		@(posedge clock);
		bm_wr <= 1'b1;
		bm_addr <= a;
		bm_wdata <= d;
		@(posedge clock);
		bm_wr <= 1'b0;
	endtask : wr
	// Data is taken once the answer has settled after the sampling edge.
	task rd(input logic [11:0] a, output pcic_word_t d);
		@(posedge clock);
		bm_rd <= 1'b1;
		bm_addr <= a;
		@(posedge clock);
		bm_rd <= 1'b0;
		#1;
		chk(bm_rvalid, 1'b1);
		d = bm_rdata;
	endtask : rd
	task wait_done;
		for (int n = 0; n < 60; n++)
		begin
			rd(`PCIC_OFS_CLEAR_REQ, rv);
			if (rv === `PCIC_DONE_CODE)
				break;
		end
		chk(rv, `PCIC_DONE_CODE);
		chk(clear_busy, 1'b0);
	endtask : wait_done
	task rx_send(input logic pass);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_data <= 8'ha5;
		@(posedge clock);
		rx_valid <= 1'b0;
		#1;
		chk(rx_out_valid, pass);
		if (pass)
			chk(rx_out_data, 8'ha5);
	endtask : rx_send
	task access_cache;
		@(posedge clock);
		hp_access <= 1'b1;
		@(posedge clock);
		hp_access <= 1'b0;
		for (int n = 0; n < 40 && hp_info_valid !== 1'b1; n++)
			@(posedge clock);
		repeat (2) @(posedge clock);
		chk(hp_fetch_req, 1'b0);
	endtask : access_cache
	task t_cpurst;
		@(posedge clock);
		cpu_reset <= 1'b1;
		repeat (4) @(posedge clock);
		cpu_reset <= 1'b0;
		repeat (4) @(posedge clock);
		#1;
		chk(hp_info_valid, 1'b0);
	endtask : t_cpurst
	task t_clear;
		@(posedge clock);
		{seq_ch1_upd, seq_ch2_upd} <= 2'b11;
		@(posedge clock);
		{seq_ch1_upd, seq_ch2_upd} <= 2'b00;
		rd(`PCIC_OFS_CH2_SEQ, rv);
		chk(rv, seq_ch2_in);
		access_cache();
		chk(hp_info_valid, 1'b1);
		rx_send(1'b1);
		chk(modem_line_on, 1'b1);
		wr(`PCIC_OFS_CLEAR_REQ, `PCIC_CLEAR_CODE);
		for (int n = 0; n < 10 && clear_busy !== 1'b1; n++)
			@(posedge clock);
		#1;
		chk(clear_busy, 1'b1);
		chk(modem_line_on, 1'b0);
		wr(`PCIC_OFS_CLEAR_REQ, 16'h1111);
		rd(`PCIC_OFS_CLEAR_REQ, rv);
		chk(rv, `PCIC_CLEAR_CODE);
		rx_send(1'b0);
		wait_done();
		rd(`PCIC_OFS_CH1_SEQ, rv);
		chk(rv, `PCIC_SEQ_INIT);
		rd(`PCIC_OFS_CH2_SEQ, rv);
		chk(rv, `PCIC_SEQ_INIT);
		chk(hp_info_valid, 1'b0);
		rx_send(1'b1);
	endtask : t_clear
	task t_defer;
		@(posedge clock);
		reinit_busy <= 1'b1;
		wr(`PCIC_OFS_CLEAR_REQ, `PCIC_CLEAR_CODE);
		repeat (3 * CLR) @(posedge clock);
		rd(`PCIC_OFS_CLEAR_REQ, rv);
		chk(rv, `PCIC_CLEAR_CODE);
		@(posedge clock);
		reinit_busy <= 1'b0;
		wait_done();
	endtask : t_defer
	task t_other;
		access_cache();
		wr(`PCIC_OFS_CLEAR_REQ, 16'h1234);
		repeat (6) @(posedge clock);
		#1;
		chk(clear_busy, 1'b0);
		chk(hp_info_valid, 1'b1);
		rd(`PCIC_OFS_CLEAR_REQ, rv);
		chk(rv, 16'h1234);
		wr(`PCIC_OFS_CLEAR_REQ, 16'h0000);
		wr(`PCIC_OFS_CH1_SEQ, 16'hffff);
		rd(`PCIC_OFS_CH1_SEQ, rv);
		chk(rv, `PCIC_SEQ_INIT);
		wr(12'h150, 16'hbeef);
		rd(12'h150, rv);
		chk(rv, 16'h0000);
	endtask : t_other
	task t_nak;
		@(posedge clock);
		nak_ch1 <= 1'b1;
		nak_code <= 16'h7155;
		@(posedge clock);
		nak_ch1 <= 1'b0;
		nak_ch2 <= 1'b1;
		nak_code <= 16'h7156;
		@(posedge clock);
		nak_ch2 <= 1'b0;
		rd(`PCIC_OFS_CH1_ERR, rv);
		chk(rv, 16'h7155);
		rd(`PCIC_OFS_CH2_ERR, rv);
		chk(rv, 16'h7156);
		wr(`PCIC_OFS_CH1_ERR, 16'h0000);
		rd(`PCIC_OFS_CH1_ERR, rv);
		chk(rv, 16'h0000);
		@(posedge clock);
		bm_wr <= 1'b1;
		bm_addr <= `PCIC_OFS_CH1_ERR;
		bm_wdata <= 16'h0000;
		nak_ch1 <= 1'b1;
		nak_code <= 16'h7157;
		@(posedge clock);
		bm_wr <= 1'b0;
		nak_ch1 <= 1'b0;
		rd(`PCIC_OFS_CH1_ERR, rv);
		chk(rv, 16'h7157);
		chk(err_lamp, 1'b0);
	endtask : t_nak
	task t_fetch_err;
		pcic_word_t codes [3];
		codes = '{`PCIC_ERR_RANGE, `PCIC_ERR_CMD, `PCIC_ERR_DEV};
		for (int i = 0; i < 3; i++)
		begin
			t_cpurst();
			wr(`PCIC_OFS_CH1_ERR, 16'h0000);
			bad_mode <= 3'h1 << i;
			access_cache();
			rd(`PCIC_OFS_CH1_ERR, rv);
			chk(rv, codes[i]);
		end
		bad_mode <= 3'h0;
	endtask : t_fetch_err
	initial
	begin
		{rst, bm_wr, bm_rd, cpu_reset, reinit_busy, rx_valid, hp_access} = 7'h40;
		{nak_ch1, nak_ch2, seq_ch1_upd, seq_ch2_upd, modem_present} = 5'h01;
		{bm_addr, rx_data, bad_mode, bm_wdata, nak_code} = '0;
		seq_ch1_in = 16'h0012;
		seq_ch2_in = 16'h0034;
		err_count = 0;
		checks = 0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		rd(`PCIC_OFS_CLEAR_REQ, rv);
		chk(rv, 16'h0000);
		t_clear();
		t_defer();
		t_other();
		t_cpurst();
		t_nak();
		t_fetch_err();
		tally_and_finish();
	end
	// Whole run is a few hundred cycles; this bound of 20000 cycles leaves ample margin.
	initial
	begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule : cpu_info_clear_handler_test
